// ---- flicker_line_filter.sv ----
// Three-line vertical flicker filter with flip-flop line stores
`default_nettype none
module flicker_line_filter #(
	parameter int LINE_PIXELS = 720
) (
	// Clock, reset, freeze
	input  wire logic           core_clk,
	input  wire logic           resetn,
	input  wire logic           clkEn,
	// Control
	input  wire logic           enable,
	input  wire logic           lineRestart,
	// Pixel stream
	input  wire logic           pixVld,
	input  wire vepi_pkg::ycc_t pixIn,
	output var  vepi_pkg::ycc_t pixOut,
	output logic                outVld
);
	import vepi_pkg::*;

	localparam int IW = (LINE_PIXELS > 1) ? $clog2(LINE_PIXELS) : 1;

	if (LINE_PIXELS < 2 || LINE_PIXELS > 4096) begin : gBadLine
		$error("LINE_PIXELS out of range");
	end

	typedef struct packed {
		logic [LINE_PIXELS-1:0][23:0] above;
		logic [LINE_PIXELS-1:0][23:0] centre;
		logic [IW-1:0]                idx;
		ycc_t                         out;
		logic                         vld;
	} fst_t;

	fst_t s;
	fst_t n;

	function automatic logic [7:0] vtap(input logic [7:0] a, b, c);
		return 8'((10'(a) + {1'b0, b, 1'b0} + 10'(c)) >> 2);
	endfunction : vtap

	always_comb begin
		ycc_t a;
		ycc_t c;
		n = s;
		n.vld = 1'b0;
		a = ycc_t'(s.above[s.idx]);
		c = ycc_t'(s.centre[s.idx]);
		if (pixVld) begin
			n.vld = 1'b1;
			if (enable) begin
				// Output is the middle line, one line late
				n.out.y  = vtap(a.y, c.y, pixIn.y);
				n.out.cb = vtap(a.cb, c.cb, pixIn.cb);
				n.out.cr = vtap(a.cr, c.cr, pixIn.cr);
			end else begin
				n.out = pixIn;
			end
			n.above[s.idx]  = s.centre[s.idx];
			n.centre[s.idx] = pixIn;
			if (s.idx == IW'(LINE_PIXELS - 1)) begin
				n.idx = '0;
			end else begin
				n.idx = s.idx + IW'(1);
			end
		end
		if (lineRestart) begin
			n.idx = '0;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else if (clkEn) begin
			s <= n;
		end
	end

	assign pixOut = s.out;
	assign outVld = s.vld;
endmodule : flicker_line_filter
`default_nettype wire

// ---- pixel_source.sv ----
// Host video source model driving a flat picture onto the pixel bus
`default_nettype none
module pixel_source (
	// Clock and reset
	input wire logic	core_clk,
	input wire logic	resetn,
	input wire logic	clkEn,
	// Picture to send
	input wire logic [2:0]	fmt,
	input wire vepi_pkg::ycc_t	colour,
	input wire logic [23:0]	rgb,
	input wire logic	sendCode,
	input wire logic [7:0]	code,
	// Pixel bus
	output var logic [23:0]	pins
);
	import vepi_pkg::*;
	logic [1:0]	phase_q;
	logic [2:0]	codeCnt_q;
	logic [7:0]	byteOut;
	logic [7:0]	junk;
	// Phase follows the device byte counter, both start at reset
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			phase_q <= 2'h0;
			codeCnt_q <= 3'h0;
		end else if (clkEn && codeCnt_q != 3'h0) begin
			codeCnt_q <= (codeCnt_q == 3'h4) ? 3'h0 : codeCnt_q + 3'h1;
		end else if (clkEn) begin
			phase_q <= phase_q + 2'h1;
			// Code sits where the next Cb would go
			if (sendCode && phase_q == 2'h3 && fmt == FMT_BT656)
				codeCnt_q <= 3'h1;
		end
	end
	always_comb begin
		// Unused lanes toggle so a wrong pin map shows up
		junk = {4{phase_q}};
		case (codeCnt_q)
			3'h1: byteOut = 8'hFF;
			3'h2, 3'h3: byteOut = 8'h00;
			3'h4: byteOut = code;
			// Cb, Y, Cr, Y
			default: byteOut = phase_q[0] ? colour.y :
				(phase_q[1] ? colour.cr : colour.cb);
		endcase
		case (fmt)
			FMT_YCC16: pins = {junk, colour.y, phase_q[1] ? colour.cr : colour.cb};
			FMT_YCC8, FMT_BT656: pins = {junk, byteOut, junk};
			FMT_RGB16: pins = {junk, rgb[23:19], rgb[15:10], rgb[7:3]};
			FMT_RGB24: pins = rgb;
			default: pins = {junk, junk, junk};
		endcase
	end
endmodule : pixel_source
`default_nettype wire

// ---- vepi_pkg.sv ----
// Types shared by the pixel input front end
`default_nettype none
package vepi_pkg;
	typedef enum logic [2:0] {
		FMT_YCC16 = 3'h0,
		FMT_YCC8  = 3'h1,
		FMT_BT656 = 3'h2,
		FMT_BLUE  = 3'h3,
		FMT_RGB16 = 3'h4,
		FMT_RGB24 = 3'h5
	} fmt_t;
	typedef enum logic [1:0] {
		MIX_OFF  = 2'h0,
		MIX_EXT  = 2'h1,
		MIX_INT  = 2'h2,
		MIX_HARD = 2'h3
	} mix_t;
	typedef struct packed {
		logic       caption;
		logic       flicker;
		logic       lumaLpf;
		logic       gamma;
		mix_t       mix;
		logic [2:0] fmt;
	} ctrl_t;
	typedef struct packed {
		logic [7:0] y;
		logic [7:0] cb;
		logic [7:0] cr;
	} ycc_t;
	typedef struct packed {
		logic       hi;
		logic       lo;
		logic [2:0] sel;
	} ovl_t;
	typedef struct packed {
		logic        read;
		logic        write;
		logic [3:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} avl_req_t;
	typedef struct packed {
		logic        waitrequest;
		logic [31:0] readdata;
	} avl_rsp_t;
	typedef struct packed {
		logic [7:0]        y;
		logic [7:0]        cb;
		logic [7:0]        cr;
		logic signed [8:0] chroma;
		logic [7:0]        composite;
	} vout_t;
endpackage : vepi_pkg
`default_nettype wire

// ---- vepi_regs.svh ----
// Register offsets, field positions, reset values and pixel constants
`ifndef VEPI_REGS_SVH
`define VEPI_REGS_SVH
`define VEPI_CTRL_OFS    4'h0
`define VEPI_STAT_OFS    4'h4
`define VEPI_CAPT_OFS    4'h8
`define VEPI_FMT_LSB     0
`define VEPI_MIX_LSB     4
`define VEPI_GAMMA_BIT   6
`define VEPI_LPF_BIT     7
`define VEPI_FLICK_BIT   8
`define VEPI_CAPT_BIT    9
`define VEPI_SEEN_BIT    8
`define VEPI_CTRL_RST    32'h0000_0080
`define VEPI_CAPT_RST    8'h10
`define VEPI_Y_MIN       8'h10
`define VEPI_C_ZERO      8'h80
`define VEPI_PRE_FIRST   8'hFF
`define VEPI_PRE_NEXT    8'h00
`define VEPI_EAV_BIT     4
`define VEPI_BLUE_SCREEN 24'h28F06E
`define VEPI_PAL_BLUE    24'h23D472
`define VEPI_PAL_RED     24'h4164D4
`define VEPI_PAL_MAGENTA 24'h54B8C6
`define VEPI_PAL_GREEN   24'h70483A
`define VEPI_PAL_CYAN    24'h839C2C
`define VEPI_PAL_YELLOW  24'hA22C8E
`define VEPI_PAL_WHITE   24'hEB8080
`endif

// ---- video_encoder_pixel_input.sv ----
// Pixel input front end: format decode, overlay, filters, 2x output
// Function
// - Luma below 16 is raised to 16 before processing.
// - Luma above 235 passes unchanged.
// - Chroma 128 is zero; chroma outside 16..240 is not clamped.
// - Chroma is one interleaved stream, Cb first.
// - 16-bit mode uses two lanes; 8-bit mode is demultiplexed.
// - BT.656 mode accepts embedded SAV and EAV codes.
// - 5-6-5 RGB is left shifted to 8-bit scale.
// - 24-bit RGB components run 0 black to 255 white.
// - Gamma correction applies to RGB only when enabled.
// - Blue screen ignores the pixel bus, outputs solid blue.
// - Overlay still applies over the blue screen.
// - Five overlay bits pick colour and mixing proportions.
// - Only composite is clipped; Y and C stay unclipped.
// - One clock at twice the pixel rate runs everything.
// - Pin meaning follows the selected input format.
// - 4:4:4 data is interpolated to 2x before lowpass.
// - Luma lowpass is optional; chroma lowpass always on.
// - Flicker reduction filters overlaid data over three lines.
// - Caption level is inserted into luma when enabled.
// - Overlay colour zero leaves the pixel unmixed, except next to an overlaid pixel in internal mixing.
// - 4:2:2 chroma is linearly interpolated to 4:4:4.
`include "vepi_regs.svh"
`default_nettype none
module video_encoder_pixel_input #(
	parameter int LINE_PIXELS = 720
) (
	// Clock, reset, freeze
	input  wire logic               core_clk,
	input  wire logic               resetn,
	input  wire logic               clkEn,
	// Register bus
	input  wire vepi_pkg::avl_req_t avlReq,
	output var  vepi_pkg::avl_rsp_t avlRsp,
	// Pixel and overlay inputs
	input  wire logic [23:0]        pixelInputPins,
	input  wire logic [2:0]         overlayColourSelect,
	input  wire logic               overlayMixLevelLo,
	input  wire logic               overlayMixLevelHi,
	input  wire logic               captionGate,
	// Video at twice the pixel rate
	output var  vepi_pkg::vout_t    videoOut
);
	import vepi_pkg::*;

	if (LINE_PIXELS < 2 || LINE_PIXELS > 4096) begin : gBadLine
		$error("LINE_PIXELS out of range");
	end

	typedef struct packed {
		ctrl_t            ctrl;
		logic [7:0]       captLvl;
		logic             seen;
		logic [7:0]       lastCode;
		logic             ack;
		logic [31:0]      rdata;
		logic [1:0]       byteCnt;
		logic [1:0]       preCnt;
		logic [7:0]       hCb;
		logic [7:0]       hY0;
		logic [7:0]       hCr;
		logic [7:0]       hY1;
		ycc_t             nPix;
		logic             nOdd;
		logic             nVld;
		ovl_t             nOl;
		logic             sol;
		ycc_t             pend;
		logic             pendOdd;
		ovl_t             pendOl;
		ycc_t             xPix;
		logic             xVld;
		ovl_t             xOl;
		ycc_t             cur;
		ovl_t             olCur;
		logic [2:0]       olPrev;
		ycc_t             mix;
		logic             mixVld;
		ycc_t             last;
		logic [2:0][7:0]  yT;
		logic [3:0][7:0]  cbT;
		logic [3:0][7:0]  crT;
		logic [1:0]       cPh;
		vout_t            out;
	} st_t;

	st_t  s;
	st_t  n;
	ycc_t fOut;
	logic fVld;

	function automatic ctrl_t ctrlFromWord(input logic [31:0] w);
		ctrl_t c;
		c.fmt     = w[`VEPI_FMT_LSB +: 3];
		c.mix     = mix_t'(w[`VEPI_MIX_LSB +: 2]);
		c.gamma   = w[`VEPI_GAMMA_BIT];
		c.lumaLpf = w[`VEPI_LPF_BIT];
		c.flicker = w[`VEPI_FLICK_BIT];
		c.caption = w[`VEPI_CAPT_BIT];
		return c;
	endfunction : ctrlFromWord

	function automatic logic [7:0] clampY(input logic [7:0] y);
		return (y < `VEPI_Y_MIN) ? `VEPI_Y_MIN : y;
	endfunction : clampY

	function automatic logic [7:0] avg(input logic [7:0] a, b);
		return 8'((9'(a) + 9'(b)) >> 1);
	endfunction : avg

	function automatic ycc_t avgPix(input ycc_t a, b);
		ycc_t o;
		o.y  = avg(a.y, b.y);
		o.cb = avg(a.cb, b.cb);
		o.cr = avg(a.cr, b.cr);
		return o;
	endfunction : avgPix

	// Piecewise fit of a 1/2.2 power curve
	function automatic logic [7:0] gammaFix(input logic [7:0] x);
		int v;
		v = int'(x);
		if (v < 16) begin
			v = v * 9 / 2;
		end else if (v < 64) begin
			v = 72 + (v - 16) * 21 / 16;
		end else if (v < 128) begin
			v = 135 + (v - 64) * 25 / 32;
		end else begin
			v = 185 + (v - 128) * 9 / 16;
		end
		if (v > 255) begin
			v = 255;
		end
		return 8'(v);
	endfunction : gammaFix

	// Full-scale RGB 0..255 into studio-range YCbCr
	function automatic ycc_t rgbToYcc(input logic [7:0] r, g, b);
		int yi;
		int bi;
		int ri;
		ycc_t o;
		yi = 66 * int'(r) + 129 * int'(g) + 25 * int'(b) + 128;
		bi = -38 * int'(r) - 74 * int'(g) + 112 * int'(b) + 128;
		ri = 112 * int'(r) - 94 * int'(g) - 18 * int'(b) + 128;
		o.y  = 8'((yi >>> 8) + 16);
		o.cb = 8'((bi >>> 8) + 128);
		o.cr = 8'((ri >>> 8) + 128);
		return o;
	endfunction : rgbToYcc

	function automatic ycc_t palette(input logic [2:0] sel);
		unique case (sel)
			3'h1: return ycc_t'(`VEPI_PAL_BLUE);
			3'h2: return ycc_t'(`VEPI_PAL_RED);
			3'h3: return ycc_t'(`VEPI_PAL_MAGENTA);
			3'h4: return ycc_t'(`VEPI_PAL_GREEN);
			3'h5: return ycc_t'(`VEPI_PAL_CYAN);
			3'h6: return ycc_t'(`VEPI_PAL_YELLOW);
			3'h7: return ycc_t'(`VEPI_PAL_WHITE);
			3'h0: return ycc_t'(`VEPI_PAL_WHITE);
		endcase
	endfunction : palette

	// k eighths of overlay plus the rest of pixel
	function automatic logic [7:0] blend(input logic [7:0] o, p,
		input logic [3:0] k);
		return 8'((int'(o) * int'(k) + int'(p) * (8 - int'(k))) / 8);
	endfunction : blend

	always_comb begin
		logic [7:0]  byteIn;
		logic [7:0]  chromaIn;
		logic [7:0]  rC;
		logic [7:0]  gC;
		logic [7:0]  bC;
		logic        req;
		logic        codeByte;
		logic        tick;
		fmt_t        fmt;
		mix_t        mode;
		logic [2:0]  sel;
		logic [2:0]  nxt;
		logic [3:0]  k;
		ycc_t        sm;
		ycc_t        ov;
		logic [11:0] cbSum;
		logic [11:0] crSum;
		logic [9:0]  ySum;
		logic signed [8:0] cbS;
		logic signed [8:0] crS;
		logic signed [9:0] comp;
		n = s;
		byteIn = pixelInputPins[15:8];
		chromaIn = pixelInputPins[7:0];
		rC = 8'h00;
		gC = 8'h00;
		bC = 8'h00;
		fmt = fmt_t'(s.ctrl.fmt);
		codeByte = 1'b0;
		n.nVld = 1'b0;
		n.sol = 1'b0;
		n.xVld = 1'b0;
		n.mixVld = 1'b0;

		// Bus slave: one wait cycle, write lands on the waitrequest-low edge
		req = avlReq.read || avlReq.write;
		if (req && !s.ack) begin
			n.ack = 1'b1;
			if (avlReq.read) unique case (avlReq.address)
				`VEPI_CTRL_OFS: n.rdata = 32'(s.ctrl.fmt) << `VEPI_FMT_LSB
					| 32'(s.ctrl.mix) << `VEPI_MIX_LSB
					| 32'(s.ctrl.gamma) << `VEPI_GAMMA_BIT
					| 32'(s.ctrl.lumaLpf) << `VEPI_LPF_BIT
					| 32'(s.ctrl.flicker) << `VEPI_FLICK_BIT
					| 32'(s.ctrl.caption) << `VEPI_CAPT_BIT;
				`VEPI_STAT_OFS: n.rdata = 32'(s.seen) << `VEPI_SEEN_BIT
					| 32'(s.lastCode);
				`VEPI_CAPT_OFS: n.rdata = 32'(s.captLvl);
				default:        n.rdata = 32'h0000_0000;
			endcase
		end else if (s.ack) begin
			n.ack = 1'b0;
			if (avlReq.write) begin
				unique case (avlReq.address)
					`VEPI_CTRL_OFS: begin
						if (avlReq.byteenable[0] && avlReq.byteenable[1]) begin
							n.ctrl = ctrlFromWord(avlReq.writedata);
						end
					end
					`VEPI_STAT_OFS: begin
						if (avlReq.byteenable[1]
							&& avlReq.writedata[`VEPI_SEEN_BIT]) begin
							n.seen = 1'b0;
						end
					end
					`VEPI_CAPT_OFS: begin
						if (avlReq.byteenable[0]) begin
							n.captLvl = avlReq.writedata[7:0];
						end
					end
					default: ;
				endcase
			end
		end

		// Timing reference codes; a new code outranks a status clear
		if (fmt == FMT_BT656) begin
			if (s.preCnt == 2'h3) begin
				codeByte = 1'b1;
				n.preCnt = 2'h0;
				n.lastCode = byteIn;
				n.seen = 1'b1;
				n.sol = !byteIn[`VEPI_EAV_BIT];
			end else if ((s.preCnt == 2'h0 && byteIn == `VEPI_PRE_FIRST)
				|| (s.preCnt != 2'h0 && byteIn == `VEPI_PRE_NEXT)) begin
				codeByte = 1'b1;
				n.preCnt = s.preCnt + 2'h1;
			end else begin
				n.preCnt = 2'h0;
			end
		end else begin
			n.preCnt = 2'h0;
		end
		if (codeByte) begin
			// Realign so the next data byte is taken as Cb
			n.byteCnt = (s.preCnt == 2'h3) ? 2'h0 : s.byteCnt;
		end else begin
			n.byteCnt = s.byteCnt + 2'h1;
		end
		tick = s.byteCnt[0] && !codeByte;

		// Pin meaning per format
		unique case (fmt)
			FMT_YCC16, FMT_YCC8, FMT_BT656: begin
				if (fmt == FMT_YCC16) begin
					if (tick && !s.byteCnt[1]) begin
						n.hCb = chromaIn;
						n.hY0 = byteIn;
					end else if (tick) begin
						n.hCr = chromaIn;
						n.hY1 = byteIn;
					end
				end else if (!codeByte) begin
					// Byte order Cb Y Cr Y
					unique case (s.byteCnt)
						2'h0: n.hCb = byteIn;
						2'h1: n.hY0 = byteIn;
						2'h2: n.hCr = byteIn;
						2'h3: n.hY1 = byteIn;
					endcase
				end
				if (tick && !s.byteCnt[1]) begin
					n.nPix.y = clampY(s.hY1);
					n.nOdd = 1'b1;
				end else if (tick) begin
					n.nPix.y = clampY(s.hY0);
					n.nPix.cb = s.hCb;
					n.nPix.cr = (fmt == FMT_YCC16) ? chromaIn : s.hCr;
					n.nOdd = 1'b0;
				end
			end
			FMT_RGB16, FMT_RGB24: begin
				if (fmt == FMT_RGB16) begin
					// Zero fill below the shifted bits
					bC = {pixelInputPins[4:0], 3'h0};
					gC = {pixelInputPins[10:5], 2'h0};
					rC = {pixelInputPins[15:11], 3'h0};
				end else begin
					bC = pixelInputPins[7:0];
					gC = pixelInputPins[15:8];
					rC = pixelInputPins[23:16];
				end
				if (s.ctrl.gamma) begin
					rC = gammaFix(rC);
					gC = gammaFix(gC);
					bC = gammaFix(bC);
				end
				if (tick) begin
					n.nPix = rgbToYcc(rC, gC, bC);
					n.nOdd = 1'b0;
				end
			end
			default: begin
				if (tick) begin
					n.nPix = ycc_t'(`VEPI_BLUE_SCREEN);
					n.nOdd = 1'b0;
				end
			end
		endcase
		if (tick) begin
			n.nVld = 1'b1;
			n.nOl.sel = overlayColourSelect;
			n.nOl.lo = overlayMixLevelLo;
			n.nOl.hi = overlayMixLevelHi;
		end

		// Odd pixels take the mean of the surrounding chroma
		if (s.nVld) begin
			n.xVld = 1'b1;
			n.xPix = s.pend;
			if (s.pendOdd) begin
				n.xPix.cb = avg(s.pend.cb, s.nPix.cb);
				n.xPix.cr = avg(s.pend.cr, s.nPix.cr);
			end
			n.xOl = s.pendOl;
			n.pend = s.nPix;
			n.pendOdd = s.nOdd;
			n.pendOl = s.nOl;
		end

		// Overlay mixing with one pixel of look-ahead
		mode = (fmt == FMT_RGB24) ? MIX_OFF : s.ctrl.mix;
		sel = s.olCur.sel;
		nxt = s.xOl.sel;
		k = 4'h0;
		unique case (mode)
			MIX_OFF: k = 4'h0;
			MIX_EXT: begin
				if (sel != 3'h0) begin
					unique case ({s.olCur.hi, s.olCur.lo})
						2'b00: k = 4'h0;
						2'b01: k = 4'h1;
						2'b10: k = 4'h7;
						2'b11: k = 4'h8;
					endcase
				end
			end
			MIX_HARD: k = (sel != 3'h0) ? 4'h8 : 4'h0;
			MIX_INT: begin
				if (sel != 3'h0) begin
					k = (s.olPrev != sel || nxt != sel) ? 4'h7 : 4'h8;
				end else if (nxt != 3'h0) begin
					sel = nxt;
					k = 4'h1;
				end else if (s.olPrev != 3'h0) begin
					sel = s.olPrev;
					k = 4'h1;
				end
			end
		endcase
		ov = palette(sel);
		if (s.xVld) begin
			n.mixVld = 1'b1;
			n.mix.y = blend(ov.y, s.cur.y, k);
			n.mix.cb = blend(ov.cb, s.cur.cb, k);
			n.mix.cr = blend(ov.cr, s.cur.cr, k);
			n.cur = s.xPix;
			n.olPrev = s.olCur.sel;
			n.olCur = s.xOl;
		end

		// Insert midpoint samples for the 2x stream
		sm = fVld ? avgPix(s.last, fOut) : s.last;
		if (fVld) begin
			n.last = fOut;
		end
		n.yT = {s.yT[1:0], sm.y};
		n.cbT = {s.cbT[2:0], sm.cb};
		n.crT = {s.crT[2:0], sm.cr};

		// Luma [1 2 1]/4 when enabled, chroma [1 4 6 4 1]/16 always
		ySum = 10'(s.yT[0]) + {1'b0, s.yT[1], 1'b0} + 10'(s.yT[2]);
		cbSum = 12'(sm.cb) + {2'h0, s.cbT[0], 2'h0}
			+ 12'(12'(s.cbT[1]) * 12'h006) + {2'h0, s.cbT[2], 2'h0}
			+ 12'(s.cbT[3]);
		crSum = 12'(sm.cr) + {2'h0, s.crT[0], 2'h0}
			+ 12'(12'(s.crT[1]) * 12'h006) + {2'h0, s.crT[2], 2'h0}
			+ 12'(s.crT[3]);
		n.out.y = s.ctrl.lumaLpf ? 8'(ySum >> 2) : s.yT[1];
		if (s.ctrl.caption && captionGate) begin
			n.out.y = s.captLvl;
		end
		n.out.cb = 8'(cbSum >> 4);
		n.out.cr = 8'(crSum >> 4);

		// Four-phase carrier; 128 is the chroma zero
		cbS = $signed({1'b0, n.out.cb}) - $signed({1'b0, `VEPI_C_ZERO});
		crS = $signed({1'b0, n.out.cr}) - $signed({1'b0, `VEPI_C_ZERO});
		n.cPh = s.cPh + 2'h1;
		unique case (s.cPh)
			2'h0: n.out.chroma = cbS;
			2'h1: n.out.chroma = crS;
			2'h2: n.out.chroma = -cbS;
			2'h3: n.out.chroma = -crS;
		endcase
		// Y and C stay unclipped; only the sum saturates
		comp = $signed({2'b00, n.out.y}) + 10'(n.out.chroma);
		if (comp < 0) begin
			n.out.composite = 8'h00;
		end else if (comp > 10'sd255) begin
			n.out.composite = 8'hFF;
		end else begin
			n.out.composite = comp[7:0];
		end
	end

	flicker_line_filter #(
		.LINE_PIXELS(LINE_PIXELS)
	) uFlicker (
		.core_clk   (core_clk),
		.resetn     (resetn),
		.clkEn      (clkEn),
		.enable     (s.ctrl.flicker),
		.lineRestart(s.sol),
		.pixVld     (s.mixVld),
		.pixIn      (s.mix),
		.pixOut     (fOut),
		.outVld     (fVld)
	);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.ctrl <= ctrlFromWord(`VEPI_CTRL_RST);
			s.captLvl <= `VEPI_CAPT_RST;
		end else if (clkEn) begin
			s <= n;
		end
	end

	always_comb begin
		avlRsp.waitrequest = (avlReq.read || avlReq.write) && !s.ack;
		avlRsp.readdata = s.rdata;
	end

	assign videoOut = s.out;
endmodule : video_encoder_pixel_input
`default_nettype wire

// ---- video_encoder_pixel_input_properties.sv ----
// Bus handshake and video output properties of the pixel input front end
`default_nettype none
module video_encoder_pixel_input_properties #(
	parameter int LINE_PIXELS = 720
) (
	// Clock and reset
	input wire logic	core_clk,
	input wire logic	resetn,
	input wire logic	clkEn,
	// Register bus
	input wire vepi_pkg::avl_req_t	avlReq,
	input wire vepi_pkg::avl_rsp_t	avlRsp,
	// Pixel and overlay inputs
	input wire logic [23:0]	pixelInputPins,
	input wire logic [2:0]	overlayColourSelect,
	input wire logic	overlayMixLevelLo,
	input wire logic	overlayMixLevelHi,
	input wire logic	captionGate,
	// Video
	input wire vepi_pkg::vout_t	videoOut
);
	import vepi_pkg::*;
	logic	req;
	logic [5:0]	warm_q;
	assign req = avlReq.read | avlReq.write;
	// Reset leaves zeros in the pipe, so wait until it has flushed
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
			warm_q <= 6'h00;
		else if (warm_q != 6'h3F)
			warm_q <= warm_q + 6'h01;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	new_req_wait_a: assert property (req && !$past(req) |-> avlRsp.waitrequest)
		else $error("new request not held off");
	idle_no_wait_a: assert property (!req |-> !avlRsp.waitrequest)
		else $error("waitrequest without request");
	one_wait_a: assert property (req && avlRsp.waitrequest && clkEn ##1 req
		|-> !avlRsp.waitrequest)
		else $error("request not answered after one wait");
	rearm_wait_a: assert property (req && !avlRsp.waitrequest && clkEn ##1 req
		|-> avlRsp.waitrequest)
		else $error("back to back request not held off");
	frozen_wait_a: assert property (req && avlRsp.waitrequest && !clkEn ##1 req
		|-> avlRsp.waitrequest)
		else $error("bus answered while frozen");
	read_hold_a: assert property (!(avlReq.read && avlRsp.waitrequest && clkEn)
		|=> $stable(avlRsp.readdata))
		else $error("readdata changed without read");
	unmapped_zero_a: assert property (avlReq.read && !avlRsp.waitrequest &&
		!(avlReq.address inside {4'h0, 4'h4, 4'h8}) |-> avlRsp.readdata == 32'h0)
		else $error("unmapped read not zero");
	video_freeze_a: assert property (!clkEn |=> $stable(videoOut))
		else $error("video moved while frozen");
	luma_floor_a: assert property (
		warm_q == 6'h3F |-> videoOut.y >= 8'h10)
		else $error("luma below black level");
endmodule : video_encoder_pixel_input_properties
bind video_encoder_pixel_input video_encoder_pixel_input_properties #(
	.LINE_PIXELS(LINE_PIXELS)
) u_props (
	.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .avlReq(avlReq),
	.avlRsp(avlRsp), .pixelInputPins(pixelInputPins),
	.overlayColourSelect(overlayColourSelect),
	.overlayMixLevelLo(overlayMixLevelLo),
	.overlayMixLevelHi(overlayMixLevelHi), .captionGate(captionGate),
	.videoOut(videoOut)
);
`default_nettype wire

// ---- video_encoder_pixel_input_test.sv ----
// Self-checking bench for the pixel input front end
`include "vepi_regs.svh"
`default_nettype none
module video_encoder_pixel_input_test;
	timeunit 1ns;
	timeprecision 1ps;
	import vepi_pkg::*;
	logic	core_clk, resetn, clkEn, captionGate, mixLo, mixHi, sendCode;
	logic [2:0]	ovlSel, fmtSel;
	logic [7:0]	code;
	logic [23:0]	pins, rgb;
	logic [31:0]	rdData;
	ycc_t	colour;
	avl_req_t	avlReq;
	avl_rsp_t	avlRsp;
	vout_t	videoOut;
	int	error_cnt = 0;
	int	check_count = 0;
	logic	sawClip;
	video_encoder_pixel_input #(.LINE_PIXELS(8)) i_video_encoder_pixel_input (
		.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .avlReq(avlReq),
		.avlRsp(avlRsp), .pixelInputPins(pins), .overlayColourSelect(ovlSel),
		.overlayMixLevelLo(mixLo), .overlayMixLevelHi(mixHi),
		.captionGate(captionGate), .videoOut(videoOut));
	pixel_source source (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
		.fmt(fmtSel), .colour(colour), .rgb(rgb), .sendCode(sendCode),
		.code(code), .pins(pins));
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Caller stands just after a rising edge; request is left up
	task automatic xfer(input logic wr, input logic [3:0] adr,
		input logic [31:0] wd);
		avlReq <= '{read: !wr, write: wr, address: adr, byteenable: 4'hF,
			writedata: wd};
		do @(negedge core_clk); while (avlRsp.waitrequest);
		@(posedge core_clk);
		rdData = avlRsp.readdata;
	endtask : xfer
	task automatic regWr(input logic [3:0] adr, input logic [31:0] wd);
		xfer(1'b1, adr, wd);
		avlReq <= '0;
		@(posedge core_clk);
	endtask : regWr
	task automatic regRd(input logic [3:0] adr, input logic [31:0] exp);
		xfer(1'b0, adr, 32'h0000_0000);
		avlReq <= '0;
		check("readdata", rdData, exp);
		@(posedge core_clk);
	endtask : regRd
	task automatic mode(input logic [31:0] ctrl);
		regWr(4'h0, ctrl);
		fmtSel <= ctrl[2:0];
	endtask : mode
	// Flat picture, so any settled sample must match
	task automatic seeVideo(input ycc_t exp);
		repeat (48) @(posedge core_clk);
		@(negedge core_clk);
		check("y", 32'(videoOut.y), 32'(exp.y));
		check("cb", 32'(videoOut.cb), 32'(exp.cb));
		check("cr", 32'(videoOut.cr), 32'(exp.cr));
		@(posedge core_clk);
	endtask : seeVideo
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		repeat (6000) @(posedge core_clk);
		error_cnt++;
		summarize();
	end
	initial begin
		resetn = 1'b0;
		clkEn = 1'b1;
		captionGate = 1'b0;
		{ovlSel, mixHi, mixLo} = 5'h00;
		{sendCode, code} = 9'h000;
		fmtSel = 3'h0;
		rgb = 24'h000000;
		colour = 24'h6040C0;
		avlReq = '0;
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		regRd(4'h0, 32'h0000_0080);
		regRd(4'h4, 32'h0000_0000);
		regRd(4'h8, 32'h0000_0010);
		regWr(4'hC, 32'hFFFF_FFFF);
		regRd(4'hC, 32'h0000_0000);
		xfer(1'b0, 4'h0, 32'h0000_0000);
		xfer(1'b0, 4'h8, 32'h0000_0000);
		avlReq <= '0;
		check("readdata", rdData, 32'h0000_0010);
		@(posedge core_clk);
		seeVideo(24'h6040C0);
		// Carrier swings 64 either side of zero for Cb 40, Cr C0
		repeat (4) @(negedge core_clk) check("chroma", 32'(videoOut.chroma[8] ?
			-videoOut.chroma : videoOut.chroma), 32'h40);
		@(posedge core_clk);
		mode(32'h0000_0180);
		seeVideo(24'h6040C0);
		mode(32'h0000_0080);
		colour <= 24'h0540C0;
		seeVideo(24'h1040C0);
		colour <= 24'hF0FA08;
		seeVideo(24'hF0FA08);
		sawClip = 1'b0;
		repeat (8) @(negedge core_clk) sawClip |= videoOut.composite === 8'hFF;
		check("clip", 32'(sawClip), 32'h1);
		@(posedge core_clk);
		colour <= 24'h6040C0;
		mode(32'h0000_0081);
		seeVideo(24'h6040C0);
		mode(32'h0000_0082);
		code <= 8'h9D;
		sendCode <= 1'b1;
		repeat (5) @(posedge core_clk);
		sendCode <= 1'b0;
		seeVideo(24'h6040C0);
		regRd(4'h4, 32'h0000_019D);
		regWr(4'h4, 32'h0000_0100);
		xfer(1'b0, 4'h4, 32'h0000_0000);
		avlReq <= '0;
		check("seen", 32'(rdData[8]), 32'h0);
		@(posedge core_clk);
		mode(32'h0000_0083);
		seeVideo(`VEPI_BLUE_SCREEN);
		mode(32'h0000_00B3);
		ovlSel <= 3'h7;
		seeVideo(`VEPI_PAL_WHITE);
		ovlSel <= 3'h0;
		seeVideo(`VEPI_BLUE_SCREEN);
		mode(32'h0000_0090);
		{ovlSel, mixHi, mixLo} <= 5'h07;
		seeVideo(`VEPI_PAL_BLUE);
		{mixHi, mixLo} <= 2'h0;
		seeVideo(24'h6040C0);
		// Internal mixing ignores the level pins on a steady overlay
		mode(32'h0000_00A0);
		seeVideo(`VEPI_PAL_BLUE);
		ovlSel <= 3'h0;
		mode(32'h0000_0085);
		seeVideo(24'h108080);
		rgb <= 24'hFFFFFF;
		seeVideo(24'hEB8080);
		mode(32'h0000_0084);
		seeVideo(24'hE77F7F);
		mode(32'h0000_00C5);
		rgb <= 24'h404040;
		seeVideo(24'h848080);
		mode(32'h0000_0280);
		regWr(4'h8, 32'h0000_00C0);
		captionGate <= 1'b1;
		seeVideo(24'hC040C0);
		clkEn <= 1'b0;
		fork
			xfer(1'b0, 4'h8, 32'h0000_0000);
			begin
				repeat (4) @(posedge core_clk);
				clkEn <= 1'b1;
			end
		join
		avlReq <= '0;
		check("readdata", rdData, 32'h0000_00C0);
		summarize();
	end
endmodule : video_encoder_pixel_input_test
`default_nettype wire
